/* File: src/cgm_mode_control.sv */
// Register file and mode state machine of the clock generator controller
//
// Summary of operation
// - Set oscillator-ready when external reference requested, oscillator selected and init done.
// - Clear oscillator-ready on oscillator deselect, or internal mode without reference output.
// - Fine trim bit set lengthens internal reference period; cleared shortens it.
// - Interrupt request only while loss-of-lock enable and sticky flag are both set.
// - PLL select low keeps PLL off; high keeps FLL off, in every mode.
// - Monitor enable makes loss of external clock request a reset.
// - Multiplier codes one to ten give four times the code.
// - Code zero reserved; codes eleven upward give forty.
// - Nine states; only the allowed transitions are taken, others ignored.
// - FLL engaged internal is the mode after reset.
// - FLL engaged internal: source 00, internal ref, FLL, divider 000.
// - FLL engaged internal drives main clock from FLL locked to internal ref.
// - FLL engaged external: source 00, external ref, FLL selected.
// - FLL engaged external drives main clock from FLL locked to external ref.
// - In FLL engaged modes debug clock comes from FLL; PLL held off.
// - Loss of lock sets sticky flag; write one clears; reset clears. The code sets it only on a lock loss while fllEnable or pllEnable is high.
// - Output source status reports the present mode's source, or the saved mode's while in stop, with no synchronising delay.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module cgm_mode_control (
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	input  wire cgm_pkg::cgm_apb_req_s apbReq,
	output logic [cgm_pkg::DATA_W-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire cgm_pkg::cgm_analog_s  analogIn,
	input  wire logic                  debugActive,
	input  wire logic                  stopReq,
	output logic                       irqReq,
	output logic                       resetReq,
	output logic                       fllEnable,
	output logic                       pllEnable,
	output logic [1:0]                 mainClkSel,
	output logic                       debugClkFromFll,
	output logic [5:0]                 multFactor,
	output logic                       trimLonger,
	output logic                       extRefEnable
);
	import cgm_pkg::*;

	function automatic logic [8:0] allowedFrom(input cgm_mode_e m);
		case (m)
			MODE_FLL_ENGAGED_INT:  allowedFrom = MODE_FLL_ENGAGED_EXT | MODE_FLL_BYPASSED_INT
				| MODE_FLL_BYPASSED_EXT;
			MODE_FLL_ENGAGED_EXT:  allowedFrom = MODE_FLL_ENGAGED_INT | MODE_FLL_BYPASSED_INT
				| MODE_FLL_BYPASSED_EXT;
			MODE_FLL_BYPASSED_INT: allowedFrom = MODE_FLL_ENGAGED_INT | MODE_FLL_ENGAGED_EXT
				| MODE_FLL_BYPASSED_EXT | MODE_LP_BYPASS_INT;
			MODE_FLL_BYPASSED_EXT: allowedFrom = MODE_FLL_ENGAGED_INT | MODE_FLL_ENGAGED_EXT
				| MODE_FLL_BYPASSED_INT | MODE_PLL_BYPASSED_EXT | MODE_LP_BYPASS_EXT;
			MODE_PLL_BYPASSED_EXT: allowedFrom = MODE_FLL_BYPASSED_EXT | MODE_PLL_ENGAGED_EXT
				| MODE_LP_BYPASS_EXT;
			MODE_PLL_ENGAGED_EXT:  allowedFrom = MODE_PLL_BYPASSED_EXT;
			MODE_LP_BYPASS_INT:    allowedFrom = MODE_FLL_BYPASSED_INT;
			MODE_LP_BYPASS_EXT:    allowedFrom = MODE_FLL_BYPASSED_EXT | MODE_PLL_BYPASSED_EXT;
			default:               allowedFrom = '0;
		endcase
	endfunction

	function automatic logic [1:0] sourceOf(input cgm_mode_e m);
		case (m)
			MODE_FLL_BYPASSED_INT, MODE_LP_BYPASS_INT: sourceOf = SRC_INT;
			MODE_FLL_BYPASSED_EXT, MODE_PLL_BYPASSED_EXT, MODE_LP_BYPASS_EXT: sourceOf = SRC_EXT;
			MODE_PLL_ENGAGED_EXT: sourceOf = SRC_PLL;
			default: sourceOf = SRC_FLL;
		endcase
	endfunction

	function automatic logic [5:0] multOf(input logic [3:0] code);
		if (code == VCO_MULTIPLIER_SELECT_RESERVED)
			multOf = MULT_NONE;
		else if (code > VCO_MULTIPLIER_SELECT_MAX_CODE)
			multOf = MULT_CAP;
		else
			multOf = {code, 2'b00};
	endfunction

	cgm_mode_e        state_q;
	cgm_mode_e        state_d;
	cgm_mode_e        resume_q;
	cgm_mode_e        target;
	logic [REG_W-1:0] loopCtl3_q;
	logic [REG_W-1:0] clkCtl1_q;
	logic [REG_W-1:0] clkCtl2_q;
	logic             fineTrim_q;
	logic             sticky_q;
	logic             oscReady_q;
	logic             lockLostPrev_q;
	cgm_analog_s      analogSync;

	// Analog indications cross into the bus clock first
	cgm_sync #(
		.WIDTH ($bits(cgm_analog_s))
	) u_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.asyncIn (analogIn),
		.syncOut (analogSync)
	);

	wire        setupPhase = apbReq.psel & ~apbReq.penable;
	wire        accessDone = apbReq.psel & apbReq.penable & pready;
	wire        wrEn       = accessDone & apbReq.pwrite;
	wire        hitSc      = apbReq.paddr == OFS_STATUS_CONTROL;
	wire        hitLc3     = apbReq.paddr == OFS_LOOP_CONTROL_3;
	wire        hitCc1     = apbReq.paddr == OFS_CLOCK_CONTROL_1;
	wire        hitCc2     = apbReq.paddr == OFS_CLOCK_CONTROL_2;
	wire        hitMode    = apbReq.paddr == OFS_MODE_STATUS;
	wire        mapped     = hitSc | hitLc3 | hitCc1 | hitCc2 | hitMode;
	wire        wrReadOnly = hitMode & apbReq.pwrite;
	wire [7:0]  wByte      = apbReq.pwdata[REG_W-1:0];

	wire        irqEn      = loopCtl3_q[LC3_IRQ_EN];
	wire        pllSel     = loopCtl3_q[LC3_PLL_SEL];
	wire        monitorEn  = loopCtl3_q[LC3_CME];
	wire [3:0]  vco_multiplier_select       = loopCtl3_q[LC3_VCO_MULTIPLIER_SELECT_HI:LC3_VCO_MULTIPLIER_SELECT_LO];
	wire [1:0]  srcSel     = clkCtl1_q[CC1_OUTPUT_SOURCE_SELECT_HI:CC1_OUTPUT_SOURCE_SELECT_LO];
	wire [2:0]  refDiv     = clkCtl1_q[CC1_REF_DIVIDER_HI:CC1_REF_DIVIDER_LO];
	wire        intRefSel  = clkCtl1_q[CC1_INTERNAL_REF_SELECT];
	wire        lowPower   = clkCtl1_q[CC1_LP] & ~debugActive;
	wire        oscSel     = clkCtl2_q[CC2_EXT_REF_OSC_SELECT];
	wire        refOutEn   = clkCtl2_q[CC2_ERCLK];

	wire        inExtMode  = (state_q == MODE_FLL_ENGAGED_EXT) | (state_q == MODE_FLL_BYPASSED_EXT)
		| (state_q == MODE_PLL_ENGAGED_EXT) | (state_q == MODE_PLL_BYPASSED_EXT)
		| (state_q == MODE_LP_BYPASS_EXT);
	wire        inIntMode  = (state_q == MODE_FLL_ENGAGED_INT) | (state_q == MODE_FLL_BYPASSED_INT)
		| (state_q == MODE_LP_BYPASS_INT);
	wire        fllEngaged = (state_q == MODE_FLL_ENGAGED_INT) | (state_q == MODE_FLL_ENGAGED_EXT);
	wire        fllDomain  = fllEngaged | (state_q == MODE_FLL_BYPASSED_INT)
		| (state_q == MODE_FLL_BYPASSED_EXT);
	wire        pllDomain  = (state_q == MODE_PLL_ENGAGED_EXT) | (state_q == MODE_PLL_BYPASSED_EXT);

	wire        oscSet     = (refOutEn | inExtMode) & oscSel & analogSync.oscInitDone;
	wire        oscClr     = ~oscSel | (inIntMode & ~refOutEn);
	wire        lockDrop   = analogSync.lockLost & ~lockLostPrev_q & (fllEnable | pllEnable);
	wire        stickyClr  = wrEn & hitSc & wByte[SC_STICKY] & sticky_q;

	// Target mode from the programmed selects; no match holds the present mode
	assign target =
		(srcSel == SRC_FLL && intRefSel && !pllSel && refDiv == REF_DIVIDER_NONE)
			? MODE_FLL_ENGAGED_INT :
		(srcSel == SRC_FLL && !intRefSel && !pllSel) ? MODE_FLL_ENGAGED_EXT :
		(srcSel == SRC_FLL && !intRefSel && pllSel) ? MODE_PLL_ENGAGED_EXT :
		(srcSel == SRC_INT && intRefSel && !pllSel && lowPower) ? MODE_LP_BYPASS_INT :
		(srcSel == SRC_INT && intRefSel && !pllSel && refDiv == REF_DIVIDER_NONE)
			? MODE_FLL_BYPASSED_INT :
		(srcSel == SRC_EXT && !intRefSel && lowPower) ? MODE_LP_BYPASS_EXT :
		(srcSel == SRC_EXT && !intRefSel && pllSel) ? MODE_PLL_BYPASSED_EXT :
		(srcSel == SRC_EXT && !intRefSel) ? MODE_FLL_BYPASSED_EXT : state_q;

	// Stop overrides everything and resumes the saved mode
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			MODE_STOP:
				if (!stopReq)
					state_d = resume_q;
			MODE_FLL_ENGAGED_INT, MODE_FLL_ENGAGED_EXT, MODE_FLL_BYPASSED_INT,
			MODE_FLL_BYPASSED_EXT, MODE_PLL_ENGAGED_EXT, MODE_PLL_BYPASSED_EXT,
			MODE_LP_BYPASS_INT, MODE_LP_BYPASS_EXT:
				if (stopReq)
					state_d = MODE_STOP;
				else if ((allowedFrom(state_q) & target) != '0)
					state_d = target;
			default:
				state_d = MODE_FLL_ENGAGED_INT;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q  <= MODE_FLL_ENGAGED_INT;
			resume_q <= MODE_FLL_ENGAGED_INT;
		end
		else
		begin
			state_q <= state_d;
			if (state_q != MODE_STOP)
				resume_q <= state_q;
		end
	end

	// Register writes; undocumented resets are zero, internal ref select set
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			loopCtl3_q <= LC3_RESET;
			clkCtl1_q  <= CC1_RESET;
			clkCtl2_q  <= CC2_RESET;
			fineTrim_q <= 1'b0;
		end
		else if (wrEn)
		begin
			if (hitLc3)
				loopCtl3_q <= wByte & LC3_WMASK;
			if (hitCc1)
				clkCtl1_q <= wByte & CC1_WMASK;
			if (hitCc2)
				clkCtl2_q <= wByte & CC2_WMASK;
			if (hitSc)
				fineTrim_q <= wByte[SC_TRIM];
		end
	end

	// Flags: a set in the same cycle as its clear wins
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sticky_q       <= 1'b0;
			oscReady_q     <= 1'b0;
			lockLostPrev_q <= 1'b0;
		end
		else
		begin
			lockLostPrev_q <= analogSync.lockLost;
			sticky_q       <= lockDrop | (sticky_q & ~stickyClr);
			oscReady_q     <= oscSet | (oscReady_q & ~oscClr);
		end
	end

	wire [7:0] scRead = {sticky_q, analogSync.lockDetected, pllDomain, inIntMode,
		sourceOf(state_q == MODE_STOP ? resume_q : state_q), oscReady_q, fineTrim_q};
	wire [DATA_W-1:0] rdMux =
		hitSc   ? {{(DATA_W-REG_W){1'b0}}, scRead} :
		hitLc3  ? {{(DATA_W-REG_W){1'b0}}, loopCtl3_q} :
		hitCc1  ? {{(DATA_W-REG_W){1'b0}}, clkCtl1_q} :
		hitCc2  ? {{(DATA_W-REG_W){1'b0}}, clkCtl2_q} :
		hitMode ? {{(DATA_W-9){1'b0}}, state_q} : '0;

	// One wait-free access phase; read data captured in the setup cycle
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= setupPhase;
			pslverr <= setupPhase & (~mapped | wrReadOnly);
			prdata  <= setupPhase & ~apbReq.pwrite ? rdMux : '0;
		end
	end

	// Analog control outputs, all registered
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqReq          <= 1'b0;
			resetReq        <= 1'b0;
			fllEnable       <= 1'b0;
			pllEnable       <= 1'b0;
			mainClkSel      <= SRC_FLL;
			debugClkFromFll <= 1'b0;
			multFactor      <= MULT_NONE;
			trimLonger      <= 1'b0;
			extRefEnable    <= 1'b0;
		end
		else
		begin
			irqReq          <= irqEn & sticky_q;
			resetReq        <= monitorEn & analogSync.extClockLost;
			fllEnable       <= ~pllSel & fllDomain;
			pllEnable       <= pllSel & pllDomain;
			mainClkSel      <= sourceOf(state_q);
			debugClkFromFll <= fllDomain;
			multFactor      <= multOf(vco_multiplier_select);
			trimLonger      <= fineTrim_q;
			extRefEnable    <= refOutEn | inExtMode;
		end
	end

	property p_osc_set;
		@(posedge sys_clk) disable iff (!arst_n) oscSet |=> oscReady_q;
	endproperty
	a_osc_set: assert property (p_osc_set) else $error("osc ready not set");

	property p_osc_clear;
		@(posedge sys_clk) disable iff (!arst_n)
			$fell(oscReady_q) |-> $past(oscClr) && !$past(oscSet);
	endproperty
	a_osc_clear: assert property (p_osc_clear) else $error("osc ready cleared wrongly");

	property p_irq;
		@(posedge sys_clk) disable iff (!arst_n) irqReq |-> $past(irqEn) && $past(sticky_q);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without enable and flag");

	property p_loop_excl;
		@(posedge sys_clk) disable iff (!arst_n)
			(!pllEnable || $past(pllSel)) && (!fllEnable || !$past(pllSel));
	endproperty
	a_loop_excl: assert property (p_loop_excl) else $error("both loops enabled");

	property p_monitor;
		@(posedge sys_clk) disable iff (!arst_n)
			!monitorEn ##1 !monitorEn |-> !resetReq;
	endproperty
	a_monitor: assert property (p_monitor) else $error("reset request with monitor off");

	property p_mult;
		@(posedge sys_clk) disable iff (!arst_n)
			$past(vco_multiplier_select) > VCO_MULTIPLIER_SELECT_MAX_CODE |-> multFactor == MULT_CAP;
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier not capped");

	property p_onehot;
		@(posedge sys_clk) disable iff (!arst_n)
			$onehot(state_q) && ($stable(state_q) || $past(state_q) == MODE_STOP
				|| state_q == MODE_STOP
				|| (allowedFrom(cgm_mode_e'($past(state_q))) & state_q) != '0);
	endproperty
	a_onehot: assert property (p_onehot) else $error("illegal mode transition");
	property p_sticky;
		@(posedge sys_clk) disable iff (!arst_n)
			lockDrop |=> sticky_q ##1 (sticky_q || $past(stickyClr));
	endproperty
	a_sticky: assert property (p_sticky) else $error("lock loss flag lost");

	property p_debug_clk;
		@(posedge sys_clk) disable iff (!arst_n)
			fllEngaged |=> debugClkFromFll && !pllEnable && mainClkSel == SRC_FLL;
	endproperty
	a_debug_clk: assert property (p_debug_clk) else $error("engaged FLL outputs wrong");

endmodule

/* File: src/cgm_pkg.sv */
// Package of constants and types for the clock generator mode control block
package cgm_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LOOP_CONTROL_3  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_CONTROL_1 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_CONTROL_2 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_MODE_STATUS     = 8'h10;

	// Status and control field positions
	localparam int SC_STICKY = 7;
	localparam int SC_TRIM   = 0;

	// Loop control three field positions
	localparam int LC3_IRQ_EN  = 7;
	localparam int LC3_PLL_SEL = 6;
	localparam int LC3_CME     = 5;
	localparam int LC3_VCO_MULTIPLIER_SELECT_HI = 3;
	localparam int LC3_VCO_MULTIPLIER_SELECT_LO = 0;
	localparam logic [REG_W-1:0] LC3_WMASK = 8'hEF;
	localparam logic [REG_W-1:0] LC3_RESET = 8'h00;

	// Clock control one field positions
	localparam int CC1_OUTPUT_SOURCE_SELECT_HI = 7;
	localparam int CC1_OUTPUT_SOURCE_SELECT_LO = 6;
	localparam int CC1_REF_DIVIDER_HI = 5;
	localparam int CC1_REF_DIVIDER_LO = 3;
	localparam int CC1_INTERNAL_REF_SELECT   = 2;
	localparam int CC1_LP      = 1;
	localparam logic [REG_W-1:0] CC1_WMASK = 8'hFE;
	localparam logic [REG_W-1:0] CC1_RESET = 8'h04;

	// Clock control two field positions
	localparam int CC2_RANGE  = 5;
	localparam int CC2_EXT_REF_OSC_SELECT  = 2;
	localparam int CC2_ERCLK  = 1;
	localparam logic [REG_W-1:0] CC2_WMASK = 8'h26;
	localparam logic [REG_W-1:0] CC2_RESET = 8'h00;

	// Output source encodings
	localparam logic [1:0] SRC_FLL = 2'h0;
	localparam logic [1:0] SRC_INT = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam logic [2:0] REF_DIVIDER_NONE = 3'h0;

	// Multiplier decode
	localparam logic [3:0] VCO_MULTIPLIER_SELECT_RESERVED = 4'h0;
	localparam logic [3:0] VCO_MULTIPLIER_SELECT_MAX_CODE = 4'hA;
	localparam logic [5:0] MULT_CAP      = 6'h28;
	localparam logic [5:0] MULT_NONE     = 6'h00;

	localparam int SYNC_STAGES = 2;

	typedef enum logic [8:0] {
		MODE_FLL_ENGAGED_INT  = 9'h001,
		MODE_FLL_ENGAGED_EXT  = 9'h002,
		MODE_FLL_BYPASSED_INT = 9'h004,
		MODE_FLL_BYPASSED_EXT = 9'h008,
		MODE_PLL_ENGAGED_EXT  = 9'h010,
		MODE_PLL_BYPASSED_EXT = 9'h020,
		MODE_LP_BYPASS_INT    = 9'h040,
		MODE_LP_BYPASS_EXT    = 9'h080,
		MODE_STOP             = 9'h100
	} cgm_mode_e;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} cgm_apb_req_s;

	typedef struct packed {
		logic oscInitDone;
		logic lockLost;
		logic lockDetected;
		logic extClockLost;
	} cgm_analog_s;

endpackage

/* File: src/cgm_sync.sv */
// Multi-bit two-flop level synchroniser
`timescale 1ns/1ns
module cgm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q  <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

/* File: tb/cgm_analog_model.sv */
// Behavioural oscillator and loop indications seen by the controller
`timescale 1ns/1ns
module cgm_analog_model #(
	parameter int INIT_CYCLES = 8
) (
	input  wire logic            sys_clk,
	input  wire logic            oscPowered,
	input  wire logic            lockLossCmd,
	input  wire logic            clkLossCmd,
	output cgm_pkg::cgm_analog_s analogOut
);
	import cgm_pkg::*;

	int initCount = 0;

	// Crystal needs start-up cycles; ready drops as soon as power goes
	always @(posedge sys_clk)
	begin
		if (!oscPowered)
			initCount <= 0;
		else if (initCount < INIT_CYCLES)
			initCount <= initCount + 1;
		analogOut.oscInitDone  <= oscPowered && (initCount == INIT_CYCLES);
		analogOut.lockLost     <= lockLossCmd;
		analogOut.lockDetected <= !lockLossCmd;
		analogOut.extClockLost <= clkLossCmd;
	end
endmodule

/* File: tb/clock_generator_mode_control_tb.sv */
// Self-checking bench for the clock generator mode controller
`timescale 1ns/1ns
`define CHK(name, exp, got) \
	begin \
		totalChecks++; \
		if ((got) !== (exp)) \
		begin \
			failCount++; \
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
		end \
	end
module clock_generator_mode_control_tb;
	import cgm_pkg::*;

	logic               sys_clk;
	logic               arst_n;
	cgm_apb_req_s       apbReq;
	logic [DATA_W-1:0]  prdata;
	logic               pready;
	logic               pslverr;
	cgm_analog_s        analogIn;
	logic               stopReq;
	logic               debugActive;
	logic               irqReq;
	logic               resetReq;
	logic               fllEnable;
	logic               pllEnable;
	logic [1:0]         mainClkSel;
	logic               debugClkFromFll;
	logic [5:0]         multFactor;
	logic               trimLonger;
	logic               extRefEnable;
	logic               lockLossCmd;
	logic               clkLossCmd;
	logic [DATA_W-1:0]  rdat;
	logic               lastErr;
	logic [5:0]         expMult;
	int                 failCount;
	int                 totalChecks;
	int                 i;
	logic [7:0]         modeCtl [4] = '{8'h00, 8'h80, 8'h44, 8'h04};
	logic [8:0]         modeExp [4] = '{9'h002, 9'h008, 9'h004, 9'h001};
	logic [1:0]         selExp  [4] = '{2'h0, 2'h2, 2'h1, 2'h0};

	cgm_mode_control u_dut (
		.sys_clk         (sys_clk),
		.arst_n          (arst_n),
		.apbReq          (apbReq),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.analogIn        (analogIn),
		.debugActive     (debugActive),
		.stopReq         (stopReq),
		.irqReq          (irqReq),
		.resetReq        (resetReq),
		.fllEnable       (fllEnable),
		.pllEnable       (pllEnable),
		.mainClkSel      (mainClkSel),
		.debugClkFromFll (debugClkFromFll),
		.multFactor      (multFactor),
		.trimLonger      (trimLonger),
		.extRefEnable    (extRefEnable)
	);

	cgm_analog_model u_osc (
		.sys_clk     (sys_clk),
		.oscPowered  (extRefEnable),
		.lockLossCmd (lockLossCmd),
		.clkLossCmd  (clkLossCmd),
		.analogOut   (analogIn)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic completeRun();
		$display("Checks %0d, mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Holds the request until pready is seen, then checks that it came after one cycle
	task automatic apbXfer(input logic isWr, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] data);
		int waitCnt;
		waitCnt = 0;
		@(posedge sys_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: isWr, paddr: addr, pwdata: data};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			waitCnt++;
		end
		while (pready !== 1'b1);
		`CHK("pready wait", 1, waitCnt)
		rdat = prdata;
		lastErr = pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		apbXfer(1'b1, addr, data);
	endtask

	task automatic chkRd(input logic [ADDR_W-1:0] addr, input logic [15:0] mask,
		input logic [15:0] exp, input string name);
		apbXfer(1'b0, addr, 32'h0000_0000);
		`CHK(name, exp, rdat[15:0] & mask)
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chkOuts(input logic f, input logic [1:0] s);
		`CHK("fllEnable", f, fllEnable)
		`CHK("pllEnable", 1'b0, pllEnable)
		`CHK("mainClkSel", s, mainClkSel)
		`CHK("debugClkFromFll", 1'b1, debugClkFromFll)
	endtask

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		failCount++;
		$display("CHECK FAILED watchdog expected done seen hang");
		completeRun();
	end

	initial
	begin
		failCount = 0;
		totalChecks = 0;
		apbReq = '0;
		arst_n = 1'b0;
		stopReq = 1'b0;
		debugActive = 1'b0;
		lockLossCmd = 1'b0;
		clkLossCmd = 1'b0;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		cyc(2);
		chkOuts(1'b1, SRC_FLL);
		chkRd(OFS_LOOP_CONTROL_3, 16'h00FF, 16'h0000, "loop3");
		chkRd(OFS_CLOCK_CONTROL_1, 16'h00FF, 16'h0004, "ctl1");
		chkRd(OFS_CLOCK_CONTROL_2, 16'h00FF, 16'h0000, "ctl2");
		chkRd(OFS_MODE_STATUS, 16'hFFFF, 16'h0001, "mode");
		chkRd(OFS_STATUS_CONTROL, 16'h00BF, 16'h0010, "status");
		chkRd(8'h14, 16'hFFFF, 16'h0000, "unmapped");
		`CHK("slverr", 1'b1, lastErr)
		wr(OFS_MODE_STATUS, 32'h0000_0002);
		`CHK("slverr", 1'b1, lastErr)
		chkRd(OFS_MODE_STATUS, 16'hFFFF, 16'h0001, "mode");
		for (i = 0; i < 16; i++)
		begin
			wr(OFS_LOOP_CONTROL_3, i);
			expMult = (i == 0) ? MULT_NONE : (i > 10) ? MULT_CAP : 6'(4 * i);
			cyc(3);
			`CHK("multFactor", expMult, multFactor)
		end
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0000);
		// Software copies any stored trim value itself
		wr(OFS_STATUS_CONTROL, 32'h0000_0001);
		cyc(3);
		`CHK("trimLonger", 1'b1, trimLonger)
		wr(OFS_STATUS_CONTROL, 32'h0000_0000);
		cyc(3);
		`CHK("trimLonger", 1'b0, trimLonger)
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_CLOCK_CONTROL_1, {24'h00_0000, modeCtl[i]});
			cyc(4);
			chkRd(OFS_MODE_STATUS, 16'h01FF, {7'h00, modeExp[i]}, "mode");
			chkRd(OFS_STATUS_CONTROL, 16'h000C, {12'h000, selExp[i], 2'h0}, "src");
			chkOuts(1'b1, selExp[i]);
			`CHK("extRefEnable", logic'(i < 2), extRefEnable)
		end
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0046);
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0001, "mode");
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0044);
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0046);
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0040, "mode");
		`CHK("fllEnable", 1'b0, fllEnable)
		@(posedge sys_clk);
		debugActive <= 1'b1;
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0004, "mode");
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0044);
		@(posedge sys_clk);
		debugActive <= 1'b0;
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0004);
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0040);
		cyc(4);
		`CHK("fllEnable", 1'b0, fllEnable)
		`CHK("pllEnable", 1'b0, pllEnable)
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0001, "mode");
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0000);
		cyc(4);
		`CHK("fllEnable", 1'b1, fllEnable)
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0080);
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0040);
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0020, "mode");
		`CHK("pllEnable", 1'b1, pllEnable)
		`CHK("fllEnable", 1'b0, fllEnable)
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0000);
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0010, "mode");
		`CHK("mainClkSel", SRC_PLL, mainClkSel)
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0080);
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0000);
		wr(OFS_CLOCK_CONTROL_1, 32'h0000_0004);
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0001, "mode");
		wr(OFS_CLOCK_CONTROL_2, 32'h0000_0006);
		chkRd(OFS_STATUS_CONTROL, 16'h0002, 16'h0000, "oscReady");
		cyc(24);
		chkRd(OFS_STATUS_CONTROL, 16'h0002, 16'h0002, "oscReady");
		wr(OFS_CLOCK_CONTROL_2, 32'h0000_0002);
		cyc(4);
		chkRd(OFS_STATUS_CONTROL, 16'h0002, 16'h0000, "oscReady");
		wr(OFS_CLOCK_CONTROL_2, 32'h0000_0006);
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0020);
		@(posedge sys_clk);
		clkLossCmd <= 1'b1;
		cyc(6);
		`CHK("resetReq", 1'b1, resetReq)
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0000);
		cyc(3);
		`CHK("resetReq", 1'b0, resetReq)
		@(posedge sys_clk);
		clkLossCmd <= 1'b0;
		// Range bit left alone throughout the monitor
		wr(OFS_CLOCK_CONTROL_2, 32'h0000_0000);
		@(posedge sys_clk);
		lockLossCmd <= 1'b1;
		cyc(3);
		@(posedge sys_clk);
		lockLossCmd <= 1'b0;
		cyc(6);
		chkRd(OFS_STATUS_CONTROL, 16'h0080, 16'h0080, "sticky");
		`CHK("irqReq", 1'b0, irqReq)
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0080);
		cyc(3);
		`CHK("irqReq", 1'b1, irqReq)
		wr(OFS_STATUS_CONTROL, 32'h0000_0000);
		chkRd(OFS_STATUS_CONTROL, 16'h0080, 16'h0080, "sticky");
		wr(OFS_STATUS_CONTROL, 32'h0000_0080);
		cyc(3);
		`CHK("irqReq", 1'b0, irqReq)
		chkRd(OFS_STATUS_CONTROL, 16'h0080, 16'h0000, "sticky");
		wr(OFS_LOOP_CONTROL_3, 32'h0000_0000);
		@(posedge sys_clk);
		stopReq <= 1'b1;
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0100, "mode");
		`CHK("fllEnable", 1'b0, fllEnable)
		@(posedge sys_clk);
		stopReq <= 1'b0;
		cyc(4);
		chkRd(OFS_MODE_STATUS, 16'h01FF, 16'h0001, "mode");
		completeRun();
	end
endmodule
